//--- logic/dnh_pkg.sv
package dnh_pkg;

    // ======================================================
    // i/o window placement
    // ======================================================
    localparam logic [9:0] IO_OFFSET   = 10'h200; // added to the switch value
    localparam logic [9:0] IO_SPAN     = 10'h006; // six consecutive ports
    localparam int         SW_LSB      = 3;       // switch steps of eight ports

    // port indices inside the window (byte address is four times these)
    localparam logic [9:0] IDX_CTRL    = 10'h000;
    localparam logic [9:0] IDX_LOAD    = 10'h001;
    localparam logic [9:0] IDX_RESET   = 10'h002;
    localparam logic [9:0] IDX_FREQ0   = 10'h003;
    localparam logic [9:0] IDX_FREQ1   = 10'h004;
    localparam logic [9:0] IDX_FREQ2   = 10'h005;

    // ======================================================
    // control byte layout and reset values
    // ======================================================
    localparam int         CTRL_MBZ_BIT   = 3;
    localparam int         CTRL_EXT_BIT   = 4;
    localparam int         CTRL_ATTEN_LSB = 5;
    localparam logic [2:0] ATTEN_MAX      = 3'h7;  // 40 + 20 + 10 dB
    localparam logic [7:0] CTRL_RST       = 8'he0; // internal clock, full attenuation
    localparam logic [7:0] FREQ_RST       = 8'h00;

    // ======================================================
    // datapath widths and rates
    // ======================================================
    localparam int          ACC_W           = 24;
    localparam int          FSET_W          = 23;
    localparam int          TOP_BYTE_W      = 7;  // high latch holds bits 16..22
    localparam int          DAC_W           = 8;
    localparam longint      PCLK_HZ         = 125000000;
    localparam longint      INT_SYS_CLK_HZ  = 33554432;
    localparam longint      ACC_MOD         = longint'(1) << ACC_W;
    localparam longint      FREQ_STEP_INT_HZ = INT_SYS_CLK_HZ / ACC_MOD; // 2 Hz per unit

    // offset of an i/o port inside the window, computed modulo 2^10
    function automatic logic [9:0] dnh_port_index(input logic [9:0] io_addr,
                                                  input logic [9:0] base);
        dnh_port_index = io_addr - base;
    endfunction

endpackage

//--- logic/dnh_ctl_if.sv
// ======================================================
// settings, commands and core state passed between the latches and the core
// ======================================================
interface dnh_ctl_if;
    logic [dnh_pkg::FSET_W-1:0] fset;      // frequency setting in the latches
    logic                       load_tgl;  // flips on each frequency load write
    logic                       clear_tgl; // flips on each reset write
    logic [dnh_pkg::ACC_W-1:0]  fcw;       // active frequency control word
    logic [dnh_pkg::ACC_W-1:0]  phase;     // phase accumulator
    logic [dnh_pkg::DAC_W-1:0]  sample;    // sine sample towards the dac

    modport regs  (output fset, load_tgl, clear_tgl, input fcw, phase, sample);
    modport accum (input fset, load_tgl, clear_tgl, output fcw, phase);
    modport sine  (input phase, output sample);
endinterface

//--- logic/dnh_accum.sv
module dnh_accum (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // settings from the latches
    dnh_ctl_if.accum ctl
);

    // ======================================================
    // command edge detection
    // ======================================================
    logic                      load_seen_q;
    logic                      clear_seen_q;
    logic [dnh_pkg::ACC_W-1:0] fcw_q;
    logic [dnh_pkg::ACC_W-1:0] fcw_d;
    logic [dnh_pkg::ACC_W-1:0] phase_q;
    logic [dnh_pkg::ACC_W-1:0] phase_d;
    wire                       load_ev;
    wire                       clear_ev;

    // any transition of a toggle is one command
    assign load_ev  = ctl.load_tgl ^ load_seen_q;
    assign clear_ev = ctl.clear_tgl ^ clear_seen_q;

    // reset command wins over a load in the same cycle
    assign fcw_d   = clear_ev ? '0 :
                     load_ev  ? {1'b0, ctl.fset} : fcw_q;
    // modulo 2^24 sum, carry dropped
    assign phase_d = phase_q + fcw_q;
    assign ctl.fcw   = fcw_q;
    assign ctl.phase = phase_q;

    // frequency word and accumulator registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_seen_q  <= 1'b0;
            clear_seen_q <= 1'b0;
            fcw_q        <= '0;
            phase_q      <= '0;
        end else begin
            load_seen_q  <= ctl.load_tgl;
            clear_seen_q <= ctl.clear_tgl;
            fcw_q        <= fcw_d;
            phase_q      <= phase_d;
        end
    end

    // ======================================================
    // checks
    // ======================================================
    phase_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (phase_q == dnh_pkg::ACC_W'($past(phase_q) + $past(fcw_q))))
        else $error("phase did not advance by the frequency word");

    phase_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
        ((25'(phase_q) + 25'(fcw_q)) > 25'h0ffffff) |=> (phase_q < $past(phase_q)))
        else $error("phase did not wrap on overflow");

    fcw_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!load_ev && !clear_ev) |=> $stable(fcw_q))
        else $error("frequency word changed without a command");

    fcw_top_a: assert property (@(posedge pclk) disable iff (!presetn)
        fcw_q[dnh_pkg::ACC_W-1] == 1'b0)
        else $error("frequency word top bit set");

endmodule

//--- logic/dnh_sine.sv
module dnh_sine (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // phase in, sample out
    dnh_ctl_if.sine  ctl
);

    // ======================================================
    // quarter wave table, 64 points, amplitude 2..127
    // ======================================================
    localparam logic [7:0] QTAB [64] = '{
        8'h02, 8'h05, 8'h08, 8'h0b, 8'h0e, 8'h11, 8'h14, 8'h17,
        8'h1a, 8'h1d, 8'h20, 8'h23, 8'h26, 8'h29, 8'h2c, 8'h2f,
        8'h32, 8'h35, 8'h38, 8'h3a, 8'h3d, 8'h40, 8'h43, 8'h45,
        8'h48, 8'h4a, 8'h4d, 8'h4f, 8'h52, 8'h54, 8'h56, 8'h59,
        8'h5b, 8'h5d, 8'h5f, 8'h61, 8'h63, 8'h65, 8'h67, 8'h69,
        8'h6a, 8'h6c, 8'h6e, 8'h6f, 8'h71, 8'h72, 8'h73, 8'h75,
        8'h76, 8'h77, 8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7c,
        8'h7d, 8'h7d, 8'h7e, 8'h7e, 8'h7f, 8'h7f, 8'h7f, 8'h7f
    };

    logic [7:0] sample_q;
    wire  [5:0] raw_idx;
    wire  [5:0] tab_idx;
    wire  [7:0] mag;
    wire  [7:0] sample_d;

    // phase to amplitude: mirror odd quadrants, negate the second half
    assign raw_idx  = ctl.phase[21:16];
    assign tab_idx  = ctl.phase[22] ? ~raw_idx : raw_idx;
    assign mag      = QTAB[tab_idx];
    assign sample_d = ctl.phase[23] ? (8'h7f - mag) : (8'h80 + mag);
    assign ctl.sample = sample_q;

    // one new sample every clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_q <= 8'h80;
        end else begin
            sample_q <= sample_d;
        end
    end

    half_sign_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (sample_q[7] == !$past(ctl.phase[23])))
        else $error("sample half does not follow phase");

endmodule

//--- logic/dnh_top.sv
// Functional notes
// - Latch a data byte only on a write whose address hits our window.
// - Four byte latches set clock source, frequency and amplitude.
// - Load and reset addresses act as immediate command strobes.
// - Six consecutive ports starting at switch value with bits 2-0 cleared, plus 0x200.
// - Host writes have no timing tie to the synthesizer core; here both run on pclk.
// - Each clock the core presents one new eight-bit sample.
// - Each clock phase is derived, then converted to sine amplitude.
// - A load transition copies the latched setting into the frequency word.
// - The frequency word adds into the phase accumulator every clock.
// - The accumulator feeds the sine conversion every clock.
// - Output frequency equals clock times frequency word over 2^24.
// - At a 2^25 Hz clock each word unit gives 2 Hz.
// - Accumulator is 24 bits; step is clock over 2^24.
// - Control bit 3 zero, bit 4 external clock, bits 5-7 attenuators; here bit 3 latches and reads back whatever is written.
// - Reset write clears the frequency word and sets 70 dB attenuation.
// - Frequency setting is 23 bits, low byte first, top bit unused.
// - All eight control bits latch together on every control port write; here only when byte lane 0 is strobed.
//
// Local design decisions: the register addresses and the APB slave port.
module dnh_top (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // board address switch
    input  wire logic [9:0]  addr_switch,
    // analogue side controls
    output logic [7:0]       dac_data,
    output logic             ext_clk_sel,
    output logic [2:0]       atten_sel
);

    // ======================================================
    // shared settings between latches and core
    // ======================================================
    dnh_ctl_if ctl ();

    // later checks default to pclk and the reset
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ======================================================
    // address decode
    // ======================================================
    wire [9:0] io_addr;
    wire [9:0] base_addr;
    wire [9:0] port_idx;
    wire       in_window;
    wire       word_ok;
    wire       setup_ph;
    wire       access_ph;
    wire       wr_hit;

    // each i/o port is one aligned apb word
    assign io_addr   = paddr[11:2];
    assign base_addr = {addr_switch[9:dnh_pkg::SW_LSB], 3'h0} + dnh_pkg::IO_OFFSET;
    assign port_idx  = dnh_pkg::dnh_port_index(io_addr, base_addr);
    assign in_window = (io_addr >= base_addr) && (port_idx < dnh_pkg::IO_SPAN);
    assign word_ok   = in_window && (paddr[1:0] == 2'h0);
    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;
    // byte lane 0 carries the port data
    assign wr_hit    = access_ph && pwrite && word_ok && pstrb[0];

    // per-port write strobes
    wire wr_ctrl;
    wire wr_load;
    wire wr_reset;
    wire wr_f0;
    wire wr_f1;
    wire wr_f2;

    assign wr_ctrl  = wr_hit && (port_idx == dnh_pkg::IDX_CTRL);
    assign wr_load  = wr_hit && (port_idx == dnh_pkg::IDX_LOAD);
    assign wr_reset = wr_hit && (port_idx == dnh_pkg::IDX_RESET);
    assign wr_f0    = wr_hit && (port_idx == dnh_pkg::IDX_FREQ0);
    assign wr_f1    = wr_hit && (port_idx == dnh_pkg::IDX_FREQ1);
    assign wr_f2    = wr_hit && (port_idx == dnh_pkg::IDX_FREQ2);

    // ======================================================
    // host latches
    // ======================================================
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] freq_q [3];
    logic       load_tgl_q;
    logic       clear_tgl_q;

    // whole byte replaces the control latch; reset forces attenuators in
    always_comb begin
        if (wr_ctrl) begin
            ctrl_d = pwdata[7:0];
        end else if (wr_reset) begin
            ctrl_d = {dnh_pkg::ATTEN_MAX, ctrl_q[4:0]};
        end else begin
            ctrl_d = ctrl_q;
        end
    end

    // control latch and command toggles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q      <= dnh_pkg::CTRL_RST;
            load_tgl_q  <= 1'b0;
            clear_tgl_q <= 1'b0;
        end else begin
            ctrl_q      <= ctrl_d;
            load_tgl_q  <= load_tgl_q ^ wr_load;
            clear_tgl_q <= clear_tgl_q ^ wr_reset;
        end
    end

    // frequency setting latches, low byte first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_q[0] <= dnh_pkg::FREQ_RST;
            freq_q[1] <= dnh_pkg::FREQ_RST;
            freq_q[2] <= dnh_pkg::FREQ_RST;
        end else begin
            if (wr_f0) begin
                freq_q[0] <= pwdata[7:0];
            end
            if (wr_f1) begin
                freq_q[1] <= pwdata[7:0];
            end
            if (wr_f2) begin
                freq_q[2] <= {1'b0, pwdata[dnh_pkg::TOP_BYTE_W-1:0]};
            end
        end
    end

    // latched setting and commands go to the core as levels and toggles
    assign ctl.fset      = {freq_q[2][dnh_pkg::TOP_BYTE_W-1:0], freq_q[1], freq_q[0]};
    assign ctl.load_tgl  = load_tgl_q;
    assign ctl.clear_tgl = clear_tgl_q;

    // ======================================================
    // synthesizer core
    // ======================================================
    // 24-bit accumulator at pclk: f = pclk * word / 2^24
    dnh_accum u_accum (
        .pclk    (pclk),
        .presetn (presetn),
        .ctl     (ctl.accum)
    );

    dnh_sine u_sine (
        .pclk    (pclk),
        .presetn (presetn),
        .ctl     (ctl.sine)
    );

    // ======================================================
    // readback and apb answer
    // ======================================================
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        err_q;

    // the strobe ports read back the core state
    always_comb begin
        if (port_idx == dnh_pkg::IDX_CTRL) begin
            rdata_d = {24'h000000, ctrl_q};
        end else if (port_idx == dnh_pkg::IDX_LOAD) begin
            rdata_d = {8'h00, ctl.fcw};
        end else if (port_idx == dnh_pkg::IDX_RESET) begin
            rdata_d = {8'h00, ctl.phase};
        end else if (port_idx == dnh_pkg::IDX_FREQ0) begin
            rdata_d = {24'h000000, freq_q[0]};
        end else if (port_idx == dnh_pkg::IDX_FREQ1) begin
            rdata_d = {24'h000000, freq_q[1]};
        end else if (port_idx == dnh_pkg::IDX_FREQ2) begin
            rdata_d = {24'h000000, freq_q[2]};
        end else begin
            rdata_d = 32'h00000000;
        end
    end

    // answer captured during setup, presented in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h00000000;
            err_q   <= 1'b0;
        end else if (setup_ph) begin
            rdata_q <= (word_ok && !pwrite) ? rdata_d : 32'h00000000;
            err_q   <= !word_ok;
        end
    end

    assign prdata      = rdata_q;
    assign pready      = 1'b1;
    assign pslverr     = access_ph && err_q;
    assign dac_data    = ctl.sample;
    assign ext_clk_sel = ctrl_q[dnh_pkg::CTRL_EXT_BIT];
    assign atten_sel   = ctrl_q[7:dnh_pkg::CTRL_ATTEN_LSB];

    // ======================================================
    // checks
    // ======================================================
    wr_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_f0 |=> (freq_q[0] == $past(pwdata[7:0])))
        else $error("frequency byte not captured");

    miss_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (access_ph && pwrite && !in_window)
        |=> ($stable(ctrl_q) && $stable(ctl.fset) && $stable(load_tgl_q)))
        else $error("latch changed on a write outside the window");

    range_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        (access_ph && (io_addr == base_addr + dnh_pkg::IO_SPAN)) |-> pslverr)
        else $error("port past the window was accepted");

    load_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_load && !wr_reset) ##1 !clear_tgl_q ^ $past(clear_tgl_q)
        |-> ##1 (ctl.fcw == {1'b0, $past(ctl.fset)}))
        else $error("load strobe did not copy the setting");

    reset_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_reset |=> (atten_sel == 3'h7) ##1 (ctl.fcw == 24'h000000))
        else $error("reset strobe did not clear the word and attenuate");

    ctrl_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl |=> (ctrl_q == $past(pwdata[7:0]))
        and (ext_clk_sel == $past(pwdata[4])))
        else $error("control byte not latched whole");

    dac_track_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ctl.phase[23:16] == 8'h40) |=> (dac_data == 8'hff))
        else $error("dac sample does not follow phase");

    // read setups inside the window
    wire rd_setup;

    assign rd_setup = setup_ph && !pwrite && word_ok;

    strb_skip_a: assert property (
        (access_ph && pwrite && word_ok && !pstrb[0]) |=> ($stable(ctrl_q) && $stable(ctl.fset)))
        else $error("latch moved on a write without lane 0");

    read_quiet_a: assert property (
        (access_ph && !pwrite) |=> ($stable(ctrl_q) && $stable(ctl.fset)))
        else $error("latch moved on a read");

    ok_flag_a: assert property (
        (setup_ph && word_ok) ##1 access_ph |-> !pslverr)
        else $error("good port answered with an error");

    err_flag_a: assert property (
        (setup_ph && !word_ok) ##1 access_ph |-> pslverr)
        else $error("refused port answered without error");

    rd_miss_a: assert property (
        (setup_ph && !word_ok) |=> (prdata == 32'h00000000))
        else $error("refused read returned data");

    rd_ctrl_a: assert property (
        (rd_setup && (port_idx == dnh_pkg::IDX_CTRL)) |=> (prdata == {24'h000000, $past(ctrl_q)}))
        else $error("control readback wrong");

    rd_phase_a: assert property (
        (rd_setup && (port_idx == dnh_pkg::IDX_RESET)) |=> (prdata[23:0] == $past(ctl.phase)))
        else $error("phase readback wrong");

    ctrl_quiet_a: assert property (
        !(wr_ctrl || wr_reset) |=> $stable(ctrl_q))
        else $error("control byte moved without a write");

    clock_keep_a: assert property (
        wr_reset |=> (ctrl_q[4:0] == $past(ctrl_q[4:0])))
        else $error("reset strobe changed the clock bit");

    fset_quiet_a: assert property (
        !(wr_f0 || wr_f1 || wr_f2) |=> $stable(ctl.fset))
        else $error("setting moved without a write");

    mid_capture_a: assert property (
        wr_f1 |=> (freq_q[1] == $past(pwdata[7:0])))
        else $error("middle frequency byte not captured");

    top_drop_a: assert property (
        wr_f2 |=> (freq_q[2] == {1'b0, $past(pwdata[6:0])}))
        else $error("top frequency byte bit 7 kept");

    load_flip_a: assert property (
        wr_load |=> (load_tgl_q != $past(load_tgl_q)))
        else $error("load write gave no command");

    clear_flip_a: assert property (
        wr_reset |=> (clear_tgl_q != $past(clear_tgl_q)))
        else $error("reset write gave no command");

    load_quiet_a: assert property (
        !wr_load |=> $stable(load_tgl_q))
        else $error("load command without a write");

endmodule

//--- test/dnh_host.sv
// ======================================================
// host model: drives i/o port writes and reads over apb
// ======================================================
module dnh_host (
    // clock
    input  wire logic        pclk,
    // apb master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    int          lost        = 0;     // transfers that never completed
    logic [7:0]  ctrl_shadow = 8'he0; // last control byte sent
    logic [31:0] rdata;
    logic        rerr;
    logic [3:0]  strb        = 4'h1;  // lane mask for coming transfers

    // idle bus from time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
        pstrb   = 4'h0;
    end

    // one transfer, held until pready is seen high
    task automatic xfer(input logic wr, input logic [9:0] port, input logic [1:0] lsb,
                        input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {port, lsb};
        pwdata  <= {24'h000000, wd};
        pstrb   <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (pready !== 1'b1) begin
            lost++;
            dds_nco_host_latches_bench.stop_test();
        end else begin
            rdata   = prdata;
            rerr    = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // whole control byte, bit 3 always zero
    task automatic ctrl_wr(input logic [9:0] base, input logic [2:0] atten, input logic ext);
        ctrl_shadow = {atten, ext, 4'h0};
        xfer(1'b1, base + dnh_pkg::IDX_CTRL, 2'b00, ctrl_shadow);
    endtask

    // change attenuation only, other bits merged from the shadow
    task automatic set_atten(input logic [9:0] base, input logic [2:0] atten);
        ctrl_wr(base, atten, ctrl_shadow[4]);
    endtask

    // frequency setting, low byte first, top bit left clear
    task automatic freq_wr(input logic [9:0] base, input logic [22:0] f);
        xfer(1'b1, base + dnh_pkg::IDX_FREQ0, 2'b00, f[7:0]);
        xfer(1'b1, base + dnh_pkg::IDX_FREQ1, 2'b00, f[15:8]);
        xfer(1'b1, base + dnh_pkg::IDX_FREQ2, 2'b00, {1'b0, f[22:16]});
    endtask
endmodule

//--- test/dds_nco_host_latches_bench.sv
module dds_nco_host_latches_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ======================================================
    // signals
    // ======================================================
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [9:0]  addr_switch;
    logic [7:0]  dac_data;
    logic        ext_clk_sel;
    logic [2:0]  atten_sel;
    int          err_total;
    int          tests_run;
    int          n_hi;
    int          n_lo;
    logic [9:0]  base;
    logic [23:0] p1;
    logic [23:0] dp;

    // clock at 8 ns
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    dnh_top u_dnh_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .addr_switch(addr_switch), .dac_data(dac_data),
        .ext_clk_sel(ext_clk_sel), .atten_sel(atten_sel)
    );

    dnh_host u_dnh_host (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr)
    );

    // ======================================================
    // helpers
    // ======================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        u_dnh_host.xfer(1'b1, base + idx, 2'b00, d);
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
        u_dnh_host.xfer(1'b0, base + idx, 2'b00, 8'h00);
        chk(u_dnh_host.rdata, exp);
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    task automatic stop_test;
        err_total += u_dnh_host.lost;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        #200000;
        err_total++;
        stop_test();
    end

    // ======================================================
    // test sequence
    // ======================================================
    initial begin
        presetn     = 1'b0;
        addr_switch = 10'h000;
        err_total   = 0;
        tests_run   = 0;
        base        = 10'h200;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk(ext_clk_sel, 1'b0);
        chk(atten_sel, 3'h7);
        chk(dac_data, 8'h80);
        rd_chk(dnh_pkg::IDX_CTRL, 32'h000000e0);
        rd_chk(dnh_pkg::IDX_LOAD, 32'h00000000);
        done("reset");

        // quarter-rate tone: phase steps a quarter turn each clock
        u_dnh_host.freq_wr(base, 23'h400000);
        rd_chk(dnh_pkg::IDX_LOAD, 32'h00000000);
        wr(dnh_pkg::IDX_LOAD, 8'h5a);
        repeat (4) @(posedge pclk);
        rd_chk(dnh_pkg::IDX_LOAD, 32'h00400000);
        n_hi = 0;
        n_lo = 0;
        repeat (8) begin
            @(posedge pclk);
            #1;
            n_hi += (dac_data === 8'hff);
            n_lo += (dac_data === 8'h00);
        end
        chk(n_hi, 2);
        chk(n_lo, 2);
        done("sine");

        // every attenuation code, clock source taken from the code's low bit
        for (int a = 0; a < 8; a++) begin
            u_dnh_host.ctrl_wr(base, a[2:0], a[0]);
            #1;
            chk(atten_sel, a[2:0]);
            chk(ext_clk_sel, a[0]);
            rd_chk(dnh_pkg::IDX_CTRL, {a[2:0], a[0], 4'h0});
        end
        u_dnh_host.set_atten(base, 3'h2);
        rd_chk(dnh_pkg::IDX_CTRL, 32'h00000050);
        done("control");

        // largest setting, top bit dropped, accumulator wraps
        wr(dnh_pkg::IDX_FREQ0, 8'hff);
        wr(dnh_pkg::IDX_FREQ1, 8'hff);
        wr(dnh_pkg::IDX_FREQ2, 8'hff);
        rd_chk(dnh_pkg::IDX_FREQ2, 32'h0000007f);
        wr(dnh_pkg::IDX_LOAD, 8'h00);
        repeat (2) @(posedge pclk);
        rd_chk(dnh_pkg::IDX_LOAD, 32'h007fffff);
        // two reads three clocks apart
        u_dnh_host.xfer(1'b0, base + dnh_pkg::IDX_RESET, 2'b00, 8'h00);
        p1 = u_dnh_host.rdata[23:0];
        u_dnh_host.xfer(1'b0, base + dnh_pkg::IDX_RESET, 2'b00, 8'h00);
        dp = u_dnh_host.rdata[23:0] - p1;
        chk(dp, 24'(3 * 32'h007fffff));
        done("accumulate");

        // reset strobe: word cleared, full attenuation, clock bit kept
        u_dnh_host.ctrl_wr(base, 3'h0, 1'b1);
        wr(dnh_pkg::IDX_RESET, 8'h00);
        repeat (2) @(posedge pclk);
        #1;
        chk(atten_sel, 3'h7);
        chk(ext_clk_sel, 1'b1);
        rd_chk(dnh_pkg::IDX_CTRL, 32'h000000f0);
        rd_chk(dnh_pkg::IDX_LOAD, 32'h00000000);
        u_dnh_host.xfer(1'b0, base + dnh_pkg::IDX_RESET, 2'b00, 8'h00);
        p1 = u_dnh_host.rdata[23:0];
        rd_chk(dnh_pkg::IDX_RESET, {8'h00, p1});
        done("reset strobe");

        // moved window, low switch bits ignored, misses refused
        @(posedge pclk);
        addr_switch <= 10'h13b;
        base = 10'h338;
        u_dnh_host.ctrl_wr(base, 3'h5, 1'b0);
        rd_chk(dnh_pkg::IDX_CTRL, 32'h000000a0);
        u_dnh_host.xfer(1'b1, base - 10'h001, 2'b00, 8'hff);
        chk(u_dnh_host.rerr, 1'b1);
        u_dnh_host.xfer(1'b1, base + 10'h006, 2'b00, 8'hff);
        chk(u_dnh_host.rerr, 1'b1);
        u_dnh_host.xfer(1'b1, base, 2'b01, 8'hff);
        chk(u_dnh_host.rerr, 1'b1);
        u_dnh_host.xfer(1'b0, base + 10'h006, 2'b00, 8'h00);
        chk(u_dnh_host.rdata, 32'h00000000);
        u_dnh_host.strb = 4'he;
        wr(dnh_pkg::IDX_CTRL, 8'h1f);
        chk(u_dnh_host.rerr, 1'b0);
        u_dnh_host.strb = 4'h1;
        rd_chk(dnh_pkg::IDX_CTRL, 32'h000000a0);
        done("decode");
        stop_test();
    end
endmodule
